//--- verilog/sfcp_consts.svh
// constants for the serial frame command processor
`ifndef SFCP_CONSTS_SVH
`define SFCP_CONSTS_SVH

`define SFCP_WORD_W 32
`define SFCP_CNT_W 6
`define SFCP_CNT_OPT 6'h20
`define SFCP_CNT_SAT 6'h21
`define SFCP_CMD_NOP 32'h00000000
`define SFCP_OP_CLR_HW 5'h18
`define SFCP_OP_RD_HW 5'h19
`define SFCP_OP_WR 5'h1A
`define SFCP_OP_SET_HW 5'h1B
`define SFCP_OP_RD_BYTE 5'h09
`define SFCP_SUB_BOTH 2'h0
`define SFCP_SUB_UPPER 2'h1
`define SFCP_SUB_LOWER 2'h2
`define SFCP_BE_BOTH 2'h3
`define SFCP_BE_UPPER 2'h2
`define SFCP_BE_LOWER 2'h1
`define SFCP_PAIR_AW 7
`define SFCP_PAIR_DEPTH 128
`define SFCP_RESULT_W 14
`define SFCP_READY_RST 1'b1
`define SFCP_CLK_PERIOD_NS 10
`define SFCP_CONV_TIME_NS 1000
`define SFCP_CONV_CYCLES (`SFCP_CONV_TIME_NS / `SFCP_CLK_PERIOD_NS)
`define SFCP_CONV_CNT_W 8

`endif

//--- verilog/sfcp_pkg.sv
// types shared by the serial frame command processor files
package sfcp_pkg;

	typedef enum logic [4:0] {
		SFCP_ACQ = 5'h01,
		SFCP_FRAME = 5'h02,
		SFCP_DECODE = 5'h04,
		SFCP_EXEC = 5'h08,
		SFCP_CONV = 5'h10
	} sfcp_state_e;

	typedef struct packed {
		logic [4:0] opcode;
		logic [1:0] sub;
		logic [8:0] addr;
		logic [15:0] data;
	} sfcp_cmd_s;

	typedef struct packed {
		logic en;
		logic [1:0] be;
		logic [6:0] idx;
		logic [15:0] data;
	} sfcp_wr_s;

endpackage

//--- verilog/sfcp_pair_mem.sv
// register pair storage with byte write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_consts.svh"

module sfcp_pair_mem
(
	// clock and enable
	input wire logic clk_in,
	input wire logic ce_in,
	// read port
	input wire logic rd_en_in,
	input wire logic [`SFCP_PAIR_AW-1:0] rd_idx_in,
	output logic [15:0] rd_data_out,
	// write port
	input wire sfcp_pkg::sfcp_wr_s wr_in
);

	// one array and one read register per byte lane, so no array has two writers
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1)
		begin : g_lane
			logic [7:0] lane_mem_reg [0:`SFCP_PAIR_DEPTH-1];
			logic [7:0] lane_rd_reg;

			always_ff @(posedge clk_in)
			begin
				if (ce_in && rd_en_in)
				begin
					lane_rd_reg <= lane_mem_reg[rd_idx_in];
				end
			end

			always_ff @(posedge clk_in)
			begin
				if (ce_in && wr_in.en && wr_in.be[lane])
				begin
					lane_mem_reg[wr_in.idx] <= wr_in.data[lane*8 +: 8];
				end
			end
		end
	endgenerate

	assign rd_data_out = {g_lane[1].lane_rd_reg, g_lane[0].lane_rd_reg};

endmodule
`default_nettype wire

//--- verilog/sfcp_core.sv
// serial frame handling and command decoding for the converter host port
//
// Overview of operation
// - a frame opens on select low and closes, starting conversion, on select high
// - select falling drops the ready strobe and clears the clock counter
// - select falling drives the enabled output lanes; the 32-bit output word was loaded at the last conversion end
// - each frame starts with a cleared, no-op command holding register
// - each capture edge counts and shifts the input bit in at the bottom
// - each launch edge presents the output register top bit on selected lanes
// - select rising releases all output lanes
// - select rising hands the input shift register to the decoder
// - select rising keeps ready low while the conversion runs
// - exactly 32 capture edges make an optimal frame with a valid command
// - under 32 edges writes nothing, unless the count carries on from before a zero-capture frame; bits already shifted out stay valid
// - over 32 edges the last 32 bits received form the command
// - configuring commands are 32 bits and execute at select rising
// - the 9-bit address is a zero bit above the 8-bit register address
// - half-word commands force the lowest address bit to zero
// - opcode 11000 clears pair bits where the data field has ones
// - opcode 11011 sets pair bits where the data field has ones
// - opcode 11001 returns the 16 pair bits in the next frame
// - opcode 01001 returns only the addressed byte in the next frame
// - opcode 11010 sub-code 00 both bytes, 01 upper, 10 lower byte
// - all-zero and undefined command words change nothing
// - select transitions during a conversion are ignored
// - a byte read word carries 8 bits on top, zeros below
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_consts.svh"

module sfcp_core
(
	// core clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// link pins
	input wire logic link_sclk_in,
	input wire logic convert_select_line_in,
	input wire logic serial_data_in,
	input wire logic [1:0] lane_enable_in,
	output logic ready_strobe_out,
	output logic [1:0] serial_output_lanes_out,
	output logic [1:0] serial_output_lanes_oe_out,
	// conversion start to the converter and result from it
	input wire logic [`SFCP_RESULT_W-1:0] conv_result_in,
	output logic conv_start_out
);

	// ********************************
	// link domain
	// ********************************
	// select high holds the launch flag set; counts survive until the next frame
	logic link_idle;
	logic cap_fresh;
	logic cap_tog_reg;
	logic open_tog_reg;
	logic launch_fresh_reg;
	logic [`SFCP_CNT_W-1:0] sclk_cnt_reg;
	logic [`SFCP_WORD_W-1:0] in_shift_reg;
	logic [`SFCP_WORD_W-1:0] out_shift_reg;
	logic [`SFCP_WORD_W-1:0] out_word_reg;

	assign link_idle = convert_select_line_in | ~rst_n_in;

	// new frame restarts the count unless the frame before it left the toggles apart
	// the open toggle settles within three core cycles of select falling, before any clock
	always_ff @(posedge link_sclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cap_tog_reg <= 1'b0;
		end
		else
		begin
			cap_tog_reg <= open_tog_reg;
		end
	end

	// a zero-capture frame leaves the toggles apart, so its close takes no stale count; the next frame rejoins them and carries that count on
	assign cap_fresh = cap_tog_reg != open_tog_reg;

	// saturating count keeps long frames distinct; shift keeps the last 32 bits
	always_ff @(posedge link_sclk_in)
	begin
		if (cap_fresh)
		begin
			sclk_cnt_reg <= `SFCP_CNT_W'(1);
			in_shift_reg <= {{(`SFCP_WORD_W-1){1'b0}}, serial_data_in};
		end
		else
		begin
			if (sclk_cnt_reg != `SFCP_CNT_SAT)
			begin
				sclk_cnt_reg <= sclk_cnt_reg + `SFCP_CNT_W'(1);
			end
			in_shift_reg <= {in_shift_reg[`SFCP_WORD_W-2:0], serial_data_in};
		end
	end

	always_ff @(negedge link_sclk_in or posedge link_idle)
	begin
		if (link_idle)
		begin
			launch_fresh_reg <= 1'b1;
		end
		else
		begin
			launch_fresh_reg <= 1'b0;
		end
	end

	// shift toward the top on each launch edge
	always_ff @(negedge link_sclk_in)
	begin
		if (launch_fresh_reg)
		begin
			out_shift_reg <= {out_word_reg[`SFCP_WORD_W-2:0], 1'b0};
		end
		else
		begin
			out_shift_reg <= {out_shift_reg[`SFCP_WORD_W-2:0], 1'b0};
		end
	end

	// before the first launch edge the held output word itself supplies the msb
	logic lane_bit;
	assign lane_bit = launch_fresh_reg ? out_word_reg[`SFCP_WORD_W-1] : out_shift_reg[`SFCP_WORD_W-1];
	assign serial_output_lanes_out = {2{lane_bit}};

	// ********************************
	// core domain
	// ********************************
	logic sel_sync1_reg;
	logic sel_sync2_reg;
	logic sel_prev_reg;
	logic sel_fall;
	logic sel_rise;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sel_sync1_reg <= 1'b1;
			sel_sync2_reg <= 1'b1;
			sel_prev_reg <= 1'b1;
		end
		else if (ce_in)
		begin
			sel_sync1_reg <= convert_select_line_in;
			sel_sync2_reg <= sel_sync1_reg;
			sel_prev_reg <= sel_sync2_reg;
		end
	end

	assign sel_fall = sel_prev_reg & ~sel_sync2_reg;
	assign sel_rise = ~sel_prev_reg & sel_sync2_reg;

	sfcp_pkg::sfcp_state_e state_reg;
	sfcp_pkg::sfcp_cmd_s cmd_hold_reg;
	logic [`SFCP_CNT_W-1:0] frame_cnt_reg;
	logic [`SFCP_CONV_CNT_W-1:0] conv_cnt_reg;
	logic [15:0] rd_data;
	logic [15:0] fetched_reg;
	logic [1:0] fetch_kind_reg;
	sfcp_pkg::sfcp_wr_s wr_req;

	// decode helpers used by the read path only; the write path decodes the opcode directly
	function automatic logic is_pair_read(input sfcp_pkg::sfcp_cmd_s c);
		is_pair_read = (c.opcode == `SFCP_OP_RD_HW) && (c.data == 16'h0000);
	endfunction

	function automatic logic is_byte_read(input sfcp_pkg::sfcp_cmd_s c);
		is_byte_read = (c.opcode == `SFCP_OP_RD_BYTE) && (c.data == 16'h0000);
	endfunction

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= sfcp_pkg::SFCP_ACQ;
		end
		else if (ce_in)
		begin
			case (state_reg)
				sfcp_pkg::SFCP_ACQ:
				begin
					if (sel_fall)
					begin
						state_reg <= sfcp_pkg::SFCP_FRAME;
					end
				end
				sfcp_pkg::SFCP_FRAME:
				begin
					if (sel_rise)
					begin
						state_reg <= sfcp_pkg::SFCP_DECODE;
					end
				end
				sfcp_pkg::SFCP_DECODE:
				begin
					state_reg <= sfcp_pkg::SFCP_EXEC;
				end
				sfcp_pkg::SFCP_EXEC:
				begin
					state_reg <= sfcp_pkg::SFCP_CONV;
				end
				// select is not looked at until the conversion ends
				sfcp_pkg::SFCP_CONV:
				begin
					if (conv_cnt_reg == `SFCP_CONV_CNT_W'(`SFCP_CONV_CYCLES - 1))
					begin
						state_reg <= sfcp_pkg::SFCP_ACQ;
					end
				end
				default:
				begin
					state_reg <= sfcp_pkg::SFCP_ACQ;
				end
			endcase
		end
	end

	// command taken only once select has risen, link clock then stands still
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cmd_hold_reg <= `SFCP_CMD_NOP;
			frame_cnt_reg <= '0;
			open_tog_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			if (state_reg == sfcp_pkg::SFCP_ACQ && sel_fall)
			begin
				open_tog_reg <= ~open_tog_reg;
				cmd_hold_reg <= `SFCP_CMD_NOP;
				// counter reads zero at frame start
				frame_cnt_reg <= '0;
			end
			else if (state_reg == sfcp_pkg::SFCP_FRAME && sel_rise)
			begin
				frame_cnt_reg <= cap_fresh ? '0 : sclk_cnt_reg;
				// short frames leave the no-op in place
				if (!cap_fresh && sclk_cnt_reg >= `SFCP_CNT_OPT)
				begin
					cmd_hold_reg <= in_shift_reg;
				end
			end
		end
	end

	// pair index drops the forced-zero top bit and the lowest bit
	sfcp_pair_mem u_mem
	(
		.clk_in(clk_in),
		.ce_in(ce_in),
		.rd_en_in(state_reg == sfcp_pkg::SFCP_DECODE),
		.rd_idx_in(cmd_hold_reg.addr[7:1]),
		.rd_data_out(rd_data),
		.wr_in(wr_req)
	);

	always_comb
	begin
		wr_req.en = 1'b0;
		wr_req.be = `SFCP_BE_BOTH;
		wr_req.idx = cmd_hold_reg.addr[7:1];
		wr_req.data = cmd_hold_reg.data;
		if (state_reg == sfcp_pkg::SFCP_EXEC && !cmd_hold_reg.addr[8])
		begin
			case (cmd_hold_reg.opcode)
				`SFCP_OP_CLR_HW:
				begin
					wr_req.en = 1'b1;
					wr_req.data = rd_data & ~cmd_hold_reg.data;
				end
				`SFCP_OP_SET_HW:
				begin
					wr_req.en = 1'b1;
					wr_req.data = rd_data | cmd_hold_reg.data;
				end
				`SFCP_OP_WR:
				begin
					wr_req.en = (cmd_hold_reg.sub != 2'h3);
					case (cmd_hold_reg.sub)
						`SFCP_SUB_UPPER: wr_req.be = `SFCP_BE_UPPER;
						`SFCP_SUB_LOWER: wr_req.be = `SFCP_BE_LOWER;
						default: wr_req.be = `SFCP_BE_BOTH;
					endcase
				end
				default:
				begin
					wr_req.en = 1'b0;
				end
			endcase
		end
	end

	// remember what the next frame must return
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fetched_reg <= 16'h0000;
			fetch_kind_reg <= 2'h0;
		end
		else if (ce_in && state_reg == sfcp_pkg::SFCP_EXEC)
		begin
			fetched_reg <= rd_data;
			// addresses with the top bit set are undefined and fetch nothing
			fetch_kind_reg <= cmd_hold_reg.addr[8] ? 2'h0
				: {is_pair_read(cmd_hold_reg), is_byte_read(cmd_hold_reg)};
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			conv_cnt_reg <= '0;
		end
		else if (ce_in)
		begin
			if (state_reg == sfcp_pkg::SFCP_CONV)
			begin
				conv_cnt_reg <= conv_cnt_reg + `SFCP_CONV_CNT_W'(1);
			end
			else
			begin
				conv_cnt_reg <= '0;
			end
		end
	end

	// output word only changes while no frame is open, so the link may read it freely
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			out_word_reg <= 32'h00000000;
		end
		else if (ce_in && state_reg == sfcp_pkg::SFCP_CONV
			&& conv_cnt_reg == `SFCP_CONV_CNT_W'(`SFCP_CONV_CYCLES - 1))
		begin
			if (fetch_kind_reg[1])
			begin
				out_word_reg <= {fetched_reg, 16'h0000};
			end
			else if (fetch_kind_reg[0])
			begin
				out_word_reg <= {(cmd_hold_reg.addr[0] ? fetched_reg[15:8] : fetched_reg[7:0]), 24'h000000};
			end
			else
			begin
				out_word_reg <= {conv_result_in, 18'h00000};
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ready_strobe_out <= `SFCP_READY_RST;
			serial_output_lanes_oe_out <= 2'h0;
			conv_start_out <= 1'b0;
		end
		else if (ce_in)
		begin
			conv_start_out <= (state_reg == sfcp_pkg::SFCP_FRAME) && sel_rise;
			if (state_reg == sfcp_pkg::SFCP_ACQ && sel_fall)
			begin
				ready_strobe_out <= 1'b0;
				serial_output_lanes_oe_out <= lane_enable_in;
			end
			else if (state_reg == sfcp_pkg::SFCP_FRAME && sel_rise)
			begin
				ready_strobe_out <= 1'b0;
				serial_output_lanes_oe_out <= 2'h0;
			end
			else if (state_reg == sfcp_pkg::SFCP_CONV
				&& conv_cnt_reg == `SFCP_CONV_CNT_W'(`SFCP_CONV_CYCLES - 1))
			begin
				ready_strobe_out <= 1'b1;
			end
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_open_ready_low: assert property (ce_in && state_reg == sfcp_pkg::SFCP_ACQ && sel_fall |=> !ready_strobe_out && serial_output_lanes_oe_out == $past(lane_enable_in))
		else $error("frame open did not drop ready or take lanes");
	a_open_cmd_clear: assert property (ce_in && state_reg == sfcp_pkg::SFCP_ACQ && sel_fall |=> cmd_hold_reg == `SFCP_CMD_NOP && frame_cnt_reg == '0)
		else $error("command holding register not cleared at frame open");
	a_close_lanes_off: assert property (ce_in && state_reg == sfcp_pkg::SFCP_FRAME && sel_rise |=> serial_output_lanes_oe_out == 2'h0 && conv_start_out)
		else $error("lanes still driven after frame close");
	a_short_frame_nop: assert property (state_reg == sfcp_pkg::SFCP_EXEC && frame_cnt_reg < `SFCP_CNT_OPT |-> !wr_req.en ##1 fetch_kind_reg == 2'h0)
		else $error("short frame changed a register");
	a_conv_ready_low: assert property ($rose(state_reg == sfcp_pkg::SFCP_CONV) |-> !ready_strobe_out throughout (state_reg == sfcp_pkg::SFCP_CONV)[*8])
		else $error("ready high during conversion");
	a_conv_ignores_sel: assert property (state_reg == sfcp_pkg::SFCP_CONV && sel_fall |=> serial_output_lanes_oe_out == 2'h0 && !ready_strobe_out && cmd_hold_reg == $past(cmd_hold_reg))
		else $error("select edge accepted during conversion");
	a_ready_after_conv: assert property ($rose(ready_strobe_out) |-> $past(state_reg) == sfcp_pkg::SFCP_CONV && state_reg == sfcp_pkg::SFCP_ACQ)
		else $error("ready rose outside conversion end");
	a_set_bits: assert property (wr_req.en && cmd_hold_reg.opcode == `SFCP_OP_SET_HW |-> wr_req.data == (rd_data | cmd_hold_reg.data) && wr_req.be == `SFCP_BE_BOTH)
		else $error("bit set data wrong");
	a_clear_bits: assert property (wr_req.en && cmd_hold_reg.opcode == `SFCP_OP_CLR_HW |-> wr_req.data == (rd_data & ~cmd_hold_reg.data))
		else $error("bit clear data wrong");
	a_byte_write_lane: assert property (wr_req.en && cmd_hold_reg.opcode == `SFCP_OP_WR && cmd_hold_reg.sub == `SFCP_SUB_UPPER |-> wr_req.be == `SFCP_BE_UPPER)
		else $error("upper byte write hit wrong lane");
	a_byte_read_word: assert property ($rose(ready_strobe_out) && fetch_kind_reg == 2'h1 |-> out_word_reg[23:0] == 24'h000000)
		else $error("byte read word has low bits set");

endmodule
`default_nettype wire

//--- verilog/unused_placeholder_removed.sv
// holds no logic; the block lives in the core and pair storage files
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/sfcp_host_model.sv
// host controller model that frames transfers on the serial link
`timescale 1ns/1ps
`default_nettype none

module sfcp_host_model
(
	// link pins
	output logic sclk_out,
	output logic select_out,
	output logic sdi_out,
	input wire logic ready_in,
	input wire logic [1:0] sdo_in,
	input wire logic [1:0] oe_in
);
	// ************
	// frame driver
	// ************
	initial
	begin
		sclk_out = 1'b0;
		select_out = 1'b1;
		sdi_out = 1'b0;
	end

	// frame only after ready, command bits sent last
	task automatic xfer(input logic [63:0] bits, input int n, input bit glitch,
		output logic [31:0] got, output logic [1:0] oe_seen, output logic rdy_seen);
		int w;
		begin
			w = 0;
			got = 32'h0;
			while (ready_in !== 1'b1 && w < 400)
			begin
				#10;
				w++;
			end
			select_out = 1'b0;
			// odd offset keeps the link clock out of phase with the core clock
			#107;
			oe_seen = oe_in;
			rdy_seen = ready_in;
			for (int i = n - 1; i >= 0; i--)
			begin
				sdi_out = bits[i];
				#15 sclk_out = 1'b1;
				if (i + 32 - n >= 0)
					got[i + 32 - n] = sdo_in[0];
				#15 sclk_out = 1'b0;
			end
			// released data line must not keep its last value
			sdi_out = ~sdi_out;
			#60 select_out = 1'b1;
			// a select pulse inside the conversion, meant to be ignored
			if (glitch)
			begin
				#500 select_out = 1'b0;
				#100 select_out = 1'b1;
			end
		end
	endtask
endmodule

`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the serial frame command processor
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk_in, rst_n_in, sclk, sel, sdi, ready, conv_start;
	logic [1:0] lane_en, sdo, oe;
	logic [13:0] conv_res;
	logic [31:0] seed, exp_word, got, c;
	logic [15:0] mem [128];
	logic [4:0] ops [8] = '{5'h18, 5'h19, 5'h1A, 5'h1B, 5'h09, 5'h09, 5'h19, 5'h00};
	int fail_count, total_checks, cycles, starts, frames;

	sfcp_core uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.link_sclk_in(sclk), .convert_select_line_in(sel), .serial_data_in(sdi),
		.lane_enable_in(lane_en), .ready_strobe_out(ready), .serial_output_lanes_out(sdo),
		.serial_output_lanes_oe_out(oe), .conv_result_in(conv_res),
		.conv_start_out(conv_start));
	sfcp_host_model host (.sclk_out(sclk), .select_out(sel), .sdi_out(sdi),
		.ready_in(ready), .sdo_in(sdo), .oe_in(oe));

	// *******************
	// clock and watchdogs
	// *******************
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cycles++;
		if (conv_start === 1'b1)
			starts++;
		// roughly three times the expected run length
		if (cycles == 60000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		begin
			x = v ^ (v << 13);
			x = x ^ (x >> 17);
			return x ^ (x << 5);
		end
	endfunction

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		begin
			total_checks++;
			if (s !== e)
			begin
				fail_count++;
				$display("MISMATCH %s expected %h seen %h", what, e, s);
			end
		end
	endtask

	task automatic tally_and_finish;
		begin
			if (fail_count == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// reference behaviour: register pairs and the next output word
	task automatic model(input logic [31:0] cmd, input int n);
		logic [8:0] a;
		logic [15:0] d;
		logic [6:0] x;
		begin
			a = cmd[24:16];
			d = cmd[15:0];
			x = a[7:1];
			exp_word = {conv_res, 18'h0};
			if (n >= 32 && !a[8])
				case (cmd[31:27])
				5'h18: mem[x] = mem[x] & ~d;
				5'h1B: mem[x] = mem[x] | d;
				5'h1A:
				begin
					if (cmd[26:25] != 2'h2 && cmd[26:25] != 2'h3)
						mem[x][15:8] = d[15:8];
					if (cmd[26:25] == 2'h0 || cmd[26:25] == 2'h2)
						mem[x][7:0] = d[7:0];
				end
				5'h19: if (d == 16'h0) exp_word = {mem[x], 16'h0};
				5'h09: if (d == 16'h0) exp_word = {a[0] ? mem[x][15:8] : mem[x][7:0], 24'h0};
				default: ;
				endcase
		end
	endtask

	// ***************
	// one whole frame
	// ***************
	task automatic frame(input logic [31:0] cmd, input int n, input bit g);
		logic [1:0] o;
		logic r;
		int sh;
		begin
			@(posedge clk_in);
			seed = xs(seed);
			conv_res <= seed[13:0];
			lane_en <= seed[15:14] | 2'h1;
			@(posedge clk_in);
			host.xfer({seed, cmd}, n, g, got, o, r);
			frames++;
			sh = (n < 32) ? 32 - n : 0;
			check("word", exp_word >> sh, got >> sh);
			check("oe", {30'h0, lane_en}, {30'h0, o});
			check("ready in frame", 32'h0, {31'h0, r});
			#60;
			check("oe after", 32'h0, {30'h0, oe});
			check("ready conv", 32'h0, {31'h0, ready});
			model(cmd, n);
			for (int w = 0; w < 300 && ready !== 1'b1; w++)
				@(posedge clk_in);
			#1;
			check("ready end", 32'h1, {31'h0, ready});
			check("starts", frames, starts);
		end
	endtask

	initial
	begin
		seed = 32'h79AB;
		rst_n_in = 1'b0;
		lane_en = 2'h3;
		conv_res = 14'h0;
		exp_word = 32'h0;
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		// odd addresses: half-word writes must land on the even pair
		for (int k = 0; k < 8; k++)
			frame({5'h1A, 2'h0, 5'h0, k[2:0], 1'b1, seed[31:16]}, 32, 1'b0);
		frame(32'h0, 32, 1'b0);
		for (int k = 0; k < 80; k++)
		begin
			seed = xs(seed);
			c[31:27] = ops[seed[2:0]];
			c[26:16] = {seed[4:3], seed[9] & seed[10], 4'h0, seed[8:5]};
			c[15:0] = (c[29:27] == 3'h1 && seed[12:11] != 2'h0) ? 16'h0 : seed[31:16];
			case (seed[15:13])
			3'h0: frame(c, 20, 1'b0);
			3'h1: frame(c, 40, 1'b0);
			3'h2: frame(c, 32, 1'b1);
			3'h3: frame(c, 0, 1'b0);
			default: frame(c, 32, 1'b0);
			endcase
		end
		tally_and_finish();
	end
endmodule

`default_nettype wire
